// >>> verilog/ucc_pkg.sv
// Purpose: shared constants for the channel configuration register group
// Assumes: 125 MHz core clock, APB byte addresses are four times the word index
// Notes:   every offset, field position and reset value is named here

package ucc_pkg;

	// ==========================================================
	// bus geometry
	localparam int              ADDR_W      = 12;
	localparam int              DATA_W      = 32;
	localparam int              REG_W       = 16;
	localparam int              WORD_BYTES  = 4;

	// ==========================================================
	// word indices and byte addresses
	localparam logic [11:0]     IDX_PULLDOWN = 12'h015;
	localparam logic [11:0]     IDX_LOOPBACK = 12'h016;
	localparam logic [11:0]     IDX_INFRARED = 12'h017;
	localparam logic [11:0]     IDX_CLOCKOUT = 12'h018;
	localparam logic [11:0]     IDX_WAKEUP   = 12'h01F;
	localparam logic [11:0]     IDX_FLUSH    = 12'h040;
	localparam logic [11:0]     IDX_LEVEL    = 12'h041;
	localparam logic [11:0]     IDX_WIDE     = 12'h042;

	localparam logic [11:0]     ADDR_PULLDOWN = 12'(IDX_PULLDOWN * WORD_BYTES);
	localparam logic [11:0]     ADDR_LOOPBACK = 12'(IDX_LOOPBACK * WORD_BYTES);
	localparam logic [11:0]     ADDR_INFRARED = 12'(IDX_INFRARED * WORD_BYTES);
	localparam logic [11:0]     ADDR_CLOCKOUT = 12'(IDX_CLOCKOUT * WORD_BYTES);
	localparam logic [11:0]     ADDR_WAKEUP   = 12'(IDX_WAKEUP * WORD_BYTES);
	localparam logic [11:0]     ADDR_FLUSH    = 12'(IDX_FLUSH * WORD_BYTES);
	localparam logic [11:0]     ADDR_LEVEL    = 12'(IDX_LEVEL * WORD_BYTES);
	localparam logic [11:0]     ADDR_WIDE     = 12'(IDX_WIDE * WORD_BYTES);

	// ==========================================================
	// field positions
	localparam int              PD_PINS      = 11;
	localparam int              PD_RX_BIT    = 10;
	localparam int              LB_DATA_BIT  = 0;
	localparam int              LB_RTS_BIT   = 1;
	localparam int              LB_DTR_BIT   = 2;
	localparam int              IR_EN_BIT    = 0;
	localparam int              IR_INV_BIT   = 1;
	localparam int              IR_PULSE_BIT = 2;
	localparam int              CK_HI_LSB    = 8;
	localparam int              CK_LO_LSB    = 0;
	localparam int              CK_FIELD_W   = 8;
	localparam int              WK_RING_BIT  = 2;
	localparam int              WK_RX_BIT    = 3;
	localparam int              FL_RESET_BIT = 0;
	localparam int              FL_OPEN_BIT  = 1;
	localparam int              FL_CLOSE_BIT = 2;
	localparam int              WIDE_EN_BIT  = 0;

	// ==========================================================
	// writable masks and reset values
	localparam logic [15:0]     MASK_PULLDOWN = 16'h07FF;
	localparam logic [15:0]     MASK_LOOPBACK = 16'h0007;
	localparam logic [15:0]     MASK_INFRARED = 16'h0007;
	localparam logic [15:0]     MASK_CLOCKOUT = 16'hFFFF;
	localparam logic [15:0]     MASK_WAKEUP   = 16'h000C;
	localparam logic [15:0]     MASK_FLUSH    = 16'h0006;
	localparam logic [15:0]     MASK_WIDE     = 16'h0001;
	localparam logic [15:0]     RST_ZERO      = 16'h0000;
	localparam logic [15:0]     RST_WAKEUP    = 16'h0004;
	localparam logic [15:0]     RST_FLUSH     = 16'h0002;

	// ==========================================================
	// infrared pulse widths in sixteenths of a bit
	localparam logic [2:0]      IR_PULSE_NARROW = 3'h3;
	localparam logic [2:0]      IR_PULSE_WIDE   = 3'h4;

	// ==========================================================
	// output clock step
	localparam int              CLK_PERIOD_PS = 8000;
	localparam int              STEP_TIME_PS  = 41670;
	localparam int              STEP_CYCLES   = (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0]
	{
		CG_IDLE = 2'b00,
		CG_HIGH = 2'b01,
		CG_LOW  = 2'b10
	} ucc_clk_state_type;

endpackage

// >>> verilog/ucc_clk_if.sv
// Purpose: carries output clock settings to the generator and its level back
// Assumes: single clock domain
// Notes:   cfg side owns the counts, gen side owns the level

`timescale 1ns/10ps

interface ucc_clk_if;
	logic [7:0] high_count;
	logic [7:0] low_count;
	logic       clk_level;

	modport cfg (output high_count, output low_count, input clk_level);
	modport gen (input high_count, input low_count, output clk_level);
endinterface

// >>> verilog/ucc_clkgen.sv
// Purpose: programmable output clock with separate high and low step counts
// Assumes: counts are steps of STEP_CYCLES core cycles
// Notes:   a zero count skips that phase; both zero holds the output low

`timescale 1ns/10ps

module ucc_clkgen
	import ucc_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES
)
(
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_b,
	// settings and level
	ucc_clk_if.gen      bus
);

	// ==========================================================
	// checks
	localparam int STEP_W = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);

	if (STEP_CYC < 1)
	begin : g_bad_step
		$error("step count must be at least one cycle");
	end

	// ==========================================================
	// phase sequencer
	ucc_clk_state_type  state_q, state_d;
	logic [STEP_W-1:0]  step_q, step_d;
	logic [7:0]         unit_q, unit_d;
	logic               clk_q, clk_d;
	logic               tick;

	always_comb
	begin
		state_d = state_q;
		unit_d  = unit_q;
		tick    = (step_q == STEP_LAST);
		step_d  = tick ? '0 : step_q + 1'b1;
		case (state_q)
			CG_IDLE:
			begin
				step_d = '0;
				unit_d = 8'h00;
				// both zero leaves the clock static
				if (bus.high_count != 8'h00)
					state_d = CG_HIGH;
				else if (bus.low_count != 8'h00)
					state_d = CG_LOW;
			end
			CG_HIGH:
			begin
				if (bus.high_count == 8'h00)
				begin
					state_d = (bus.low_count == 8'h00) ? CG_IDLE : CG_LOW;
					unit_d  = 8'h00;
					step_d  = '0;
				end
				else if (tick)
				begin
					if (unit_q >= bus.high_count - 8'h01)
					begin
						unit_d = 8'h00;
						if (bus.low_count != 8'h00)
							state_d = CG_LOW;
					end
					else
						unit_d = unit_q + 8'h01;
				end
			end
			CG_LOW:
			begin
				if (bus.low_count == 8'h00)
				begin
					state_d = (bus.high_count == 8'h00) ? CG_IDLE : CG_HIGH;
					unit_d  = 8'h00;
					step_d  = '0;
				end
				else if (tick)
				begin
					if (unit_q >= bus.low_count - 8'h01)
					begin
						unit_d = 8'h00;
						if (bus.high_count != 8'h00)
							state_d = CG_HIGH;
					end
					else
						unit_d = unit_q + 8'h01;
				end
			end
			default:
			begin
				state_d = CG_IDLE;
			end
		endcase
		clk_d = (state_d == CG_HIGH);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= CG_IDLE;
			step_q  <= '0;
			unit_q  <= 8'h00;
			clk_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			step_q  <= step_d;
			unit_q  <= unit_d;
			clk_q   <= clk_d;
		end
	end

	assign bus.clk_level = clk_q;

	// ==========================================================
	// checks on the generated waveform
	a_zero_static: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.high_count == 8'h00 && bus.low_count == 8'h00) [*2] |-> !clk_q)
		else $error("output clock toggles with both counts zero");

	// a count rewritten inside the phase changes the phase length, so it releases the check
	a_high_width: assert property (@(posedge clk) disable iff (!rst_b)
		($rose(clk_q) && bus.high_count == 8'h01 && bus.low_count != 8'h00 && STEP_CYC == 6)
		|-> ((clk_q [*6] ##1 !clk_q)
		or (##[1:6] (bus.high_count != 8'h01 || bus.low_count == 8'h00))))
		else $error("high phase not one step long");

	a_low_width: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(clk_q) && bus.low_count == 8'h02 && bus.high_count != 8'h00 && STEP_CYC == 6)
		|-> ((!clk_q [*8] ##1 !clk_q [*4] ##1 clk_q)
		or (##[1:12] (bus.low_count != 8'h02 || bus.high_count == 8'h00))))
		else $error("low phase not two steps long");

endmodule

// >>> verilog/ucc_cfg_top.sv
// Purpose: per-channel pin, loopback, infrared, clock, wake and transmit queue settings
// Assumes: pins pass two flops; UART and queue signals share the core clock
// Notes:   APB slave, zero wait states, one word per register, data in bits 15:0

`timescale 1ns/10ps

module ucc_cfg_top
	import ucc_pkg::*;
#(
	parameter int LEVEL_W = 10
)
(
	// clock and reset
	input  wire logic               REF_CLK_IN,
	input  wire logic               RST_B_IN,
	// APB slave
	input  wire logic               PSEL_IN,
	input  wire logic               PENABLE_IN,
	input  wire logic               PWRITE_IN,
	input  wire logic [ADDR_W-1:0]  PADDR_IN,
	input  wire logic [DATA_W-1:0]  PWDATA_IN,
	input  wire logic [3:0]         PSTRB_IN,
	output      logic [DATA_W-1:0]  PRDATA_OUT,
	output      logic               PREADY_OUT,
	output      logic               PSLVERR_OUT,
	// pad control, bit 10 receive pin, bits 9:0 GPIO
	input  wire logic [PD_PINS-1:0] PIN_IS_INPUT_IN,
	input  wire logic [PD_PINS-1:0] PULLUP_REQ_IN,
	output      logic [PD_PINS-1:0] PULLDOWN_ON_OUT,
	// UART core side
	input  wire logic               UART_TXD_IN,
	input  wire logic               UART_RTS_IN,
	input  wire logic               UART_DTR_IN,
	output      logic               UART_RXD_OUT,
	output      logic               UART_CTS_OUT,
	output      logic               UART_DSR_OUT,
	// external pins
	output      logic               TX_PIN_OUT,
	output      logic               TX_PIN_OE_OUT,
	input  wire logic               RX_PIN_IN,
	input  wire logic               CTS_PIN_IN,
	input  wire logic               DSR_PIN_IN,
	output      logic               RTS_PIN_OUT,
	output      logic               DTR_PIN_OUT,
	input  wire logic               RING_OR_WAKE_PIN_IN,
	input  wire logic               RING_PIN_IS_INPUT_IN,
	// infrared encoder settings
	output      logic               INFRARED_CONTROL_EN_OUT,
	output      logic [2:0]         IR_PULSE_SIXTEENTHS_OUT,
	// generated clock and wakeup
	output      logic               CLOCK_OUT,
	output      logic               WAKE_EVENT_OUT,
	// transmit queue
	input  wire logic               TX_ENABLE_IN,
	input  wire logic [LEVEL_W-1:0] TX_LEVEL_IN,
	output      logic               TX_FLUSH_OUT,
	output      logic               TX_WIDE_OUT
);

	// ==========================================================
	// checks
	if (LEVEL_W < 1 || LEVEL_W > REG_W)
	begin : g_bad_level
		$error("queue level width must fit one register");
	end

	// ==========================================================
	// pin synchronisers: rx, cts, dsr, ring
	localparam int SY_RX   = 0;
	localparam int SY_CTS  = 1;
	localparam int SY_DSR  = 2;
	localparam int SY_RING = 3;

	logic [3:0] sync1_q, sync1_d;
	logic [3:0] sync2_q, sync2_d;
	logic       rx_prev_q, rx_prev_d;
	logic       ring_prev_q, ring_prev_d;

	always_comb
	begin
		sync1_d     = {RING_OR_WAKE_PIN_IN, DSR_PIN_IN, CTS_PIN_IN, RX_PIN_IN};
		sync2_d     = sync1_q;
		rx_prev_d   = sync2_q[SY_RX];
		ring_prev_d = sync2_q[SY_RING];
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			// idle-high lines reset high so no false edge at start
			sync1_q     <= 4'hF;
			sync2_q     <= 4'hF;
			rx_prev_q   <= 1'b1;
			ring_prev_q <= 1'b1;
		end
		else
		begin
			sync1_q     <= sync1_d;
			sync2_q     <= sync2_d;
			rx_prev_q   <= rx_prev_d;
			ring_prev_q <= ring_prev_d;
		end
	end

	// ==========================================================
	// APB decode
	logic        setup_rd;
	logic        wr_en;
	logic        addr_hit;
	logic [15:0] wmask;
	logic [15:0] wdat;
	logic [15:0] rd_word;

	assign setup_rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
	assign wr_en    = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign wmask    = {{8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};
	assign wdat     = PWDATA_IN[REG_W-1:0];

	// ==========================================================
	// register state
	logic [15:0]        pd_q, pd_d;
	logic [15:0]        lb_q, lb_d;
	logic [15:0]        ir_q, ir_d;
	logic [15:0]        ck_q, ck_d;
	logic [15:0]        wk_q, wk_d;
	logic [15:0]        fl_q, fl_d;
	logic [15:0]        wide_q, wide_d;
	logic [LEVEL_W-1:0] level_q, level_d;
	logic [15:0]        prdata_q, prdata_d;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
		input logic [15:0] lanes, input logic [15:0] keep);
		merge = ((old & ~lanes) | (val & lanes)) & keep;
	endfunction

	always_comb
	begin
		pd_d     = pd_q;
		lb_d     = lb_q;
		ir_d     = ir_q;
		ck_d     = ck_q;
		wk_d     = wk_q;
		fl_d     = fl_q;
		wide_d   = wide_q;
		level_d  = TX_LEVEL_IN;
		prdata_d = prdata_q;
		addr_hit = 1'b1;
		rd_word  = 16'h0000;
		// reserved bits are dropped on write and read as zero
		if (PADDR_IN == ADDR_PULLDOWN)
			rd_word = pd_q;
		else if (PADDR_IN == ADDR_LOOPBACK)
			rd_word = lb_q;
		else if (PADDR_IN == ADDR_INFRARED)
			rd_word = ir_q;
		else if (PADDR_IN == ADDR_CLOCKOUT)
			rd_word = ck_q;
		else if (PADDR_IN == ADDR_WAKEUP)
			rd_word = wk_q;
		else if (PADDR_IN == ADDR_FLUSH)
			rd_word = 16'h0000;
		else if (PADDR_IN == ADDR_LEVEL)
			rd_word = 16'(level_q);
		else if (PADDR_IN == ADDR_WIDE)
			rd_word = wide_q;
		else
			addr_hit = 1'b0;
		if (setup_rd)
			prdata_d = rd_word;
		if (wr_en)
		begin
			if (PADDR_IN == ADDR_PULLDOWN)
				pd_d = merge(pd_q, wdat, wmask, MASK_PULLDOWN);
			else if (PADDR_IN == ADDR_LOOPBACK)
				lb_d = merge(lb_q, wdat, wmask, MASK_LOOPBACK);
			else if (PADDR_IN == ADDR_INFRARED)
				ir_d = merge(ir_q, wdat, wmask, MASK_INFRARED);
			else if (PADDR_IN == ADDR_CLOCKOUT)
				ck_d = merge(ck_q, wdat, wmask, MASK_CLOCKOUT);
			else if (PADDR_IN == ADDR_WAKEUP)
				wk_d = merge(wk_q, wdat, wmask, MASK_WAKEUP);
			else if (PADDR_IN == ADDR_FLUSH)
				fl_d = merge(fl_q, wdat, wmask, MASK_FLUSH);
			else if (PADDR_IN == ADDR_WIDE)
				wide_d = merge(wide_q, wdat, wmask, MASK_WIDE);
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			pd_q     <= RST_ZERO;
			lb_q     <= RST_ZERO;
			ir_q     <= RST_ZERO;
			ck_q     <= RST_ZERO;
			wk_q     <= RST_WAKEUP;
			fl_q     <= RST_FLUSH;
			wide_q   <= RST_ZERO;
			level_q  <= '0;
			prdata_q <= RST_ZERO;
		end
		else
		begin
			pd_q     <= pd_d;
			lb_q     <= lb_d;
			ir_q     <= ir_d;
			ck_q     <= ck_d;
			wk_q     <= wk_d;
			fl_q     <= fl_d;
			wide_q   <= wide_d;
			level_q  <= level_d;
			prdata_q <= prdata_d;
		end
	end

	// zero wait states; the error only marks the access phase
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;
	assign PRDATA_OUT  = {{(DATA_W - REG_W){1'b0}}, prdata_q};

	// ==========================================================
	// pins, loopback, wake and queue control
	logic [PD_PINS-1:0] pdn_q, pdn_d;
	logic               rxd_q, rxd_d;
	logic               cts_q, cts_d;
	logic               dsr_q, dsr_d;
	logic               txp_q, txp_d;
	logic               txoe_q, txoe_d;
	logic               rts_q, rts_d;
	logic               dtr_q, dtr_d;
	logic               wake_q, wake_d;
	logic               flush_q, flush_d;
	logic               txen_prev_q, txen_prev_d;
	logic               rx_ext;

	always_comb
	begin
		// no GPIO versus alternate split: only direction and pull-up request matter
		pdn_d  = pd_q[PD_PINS-1:0] & PIN_IS_INPUT_IN & ~PULLUP_REQ_IN;
		rx_ext = sync2_q[SY_RX] ^ ir_q[IR_INV_BIT];
		rxd_d  = lb_q[LB_DATA_BIT] ? UART_TXD_IN : rx_ext;
		txp_d  = UART_TXD_IN;
		txoe_d = !lb_q[LB_DATA_BIT];
		cts_d  = lb_q[LB_RTS_BIT] ? UART_RTS_IN : sync2_q[SY_CTS];
		dsr_d  = lb_q[LB_DTR_BIT] ? UART_DTR_IN : sync2_q[SY_DSR];
		rts_d  = UART_RTS_IN;
		dtr_d  = UART_DTR_IN;
		wake_d = (wk_q[WK_RX_BIT] && PIN_IS_INPUT_IN[PD_RX_BIT]
			&& rx_prev_q && !sync2_q[SY_RX])
			|| (wk_q[WK_RING_BIT] && RING_PIN_IS_INPUT_IN
			&& ring_prev_q && !sync2_q[SY_RING]);
		txen_prev_d = TX_ENABLE_IN;
		flush_d = (wr_en && PADDR_IN == ADDR_FLUSH && PSTRB_IN[0] && wdat[FL_RESET_BIT])
			|| (fl_q[FL_OPEN_BIT] && TX_ENABLE_IN && !txen_prev_q)
			|| (fl_q[FL_CLOSE_BIT] && !TX_ENABLE_IN && txen_prev_q);
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			pdn_q       <= '0;
			rxd_q       <= 1'b1;
			cts_q       <= 1'b1;
			dsr_q       <= 1'b1;
			txp_q       <= 1'b1;
			txoe_q      <= 1'b1;
			rts_q       <= 1'b1;
			dtr_q       <= 1'b1;
			wake_q      <= 1'b0;
			flush_q     <= 1'b0;
			txen_prev_q <= 1'b0;
		end
		else
		begin
			pdn_q       <= pdn_d;
			rxd_q       <= rxd_d;
			cts_q       <= cts_d;
			dsr_q       <= dsr_d;
			txp_q       <= txp_d;
			txoe_q      <= txoe_d;
			rts_q       <= rts_d;
			dtr_q       <= dtr_d;
			wake_q      <= wake_d;
			flush_q     <= flush_d;
			txen_prev_q <= txen_prev_d;
		end
	end

	assign PULLDOWN_ON_OUT = pdn_q;
	assign UART_RXD_OUT    = rxd_q;
	assign UART_CTS_OUT    = cts_q;
	assign UART_DSR_OUT    = dsr_q;
	assign TX_PIN_OUT      = txp_q;
	assign TX_PIN_OE_OUT   = txoe_q;
	assign RTS_PIN_OUT     = rts_q;
	assign DTR_PIN_OUT     = dtr_q;
	assign WAKE_EVENT_OUT  = wake_q;
	assign TX_FLUSH_OUT    = flush_q;
	assign TX_WIDE_OUT     = wide_q[WIDE_EN_BIT];
	assign INFRARED_CONTROL_EN_OUT  = ir_q[IR_EN_BIT];
	assign IR_PULSE_SIXTEENTHS_OUT = ir_q[IR_PULSE_BIT] ? IR_PULSE_WIDE : IR_PULSE_NARROW;

	// ==========================================================
	// output clock generator
	ucc_clk_if clk_bus ();

	assign clk_bus.high_count = ck_q[CK_HI_LSB +: CK_FIELD_W];
	assign clk_bus.low_count  = ck_q[CK_LO_LSB +: CK_FIELD_W];
	assign CLOCK_OUT          = clk_bus.clk_level;

	ucc_clkgen #(
		.STEP_CYC (STEP_CYCLES)
	) u_clkgen (
		.clk   (REF_CLK_IN),
		.rst_b (RST_B_IN),
		.bus   (clk_bus.gen)
	);

	// ==========================================================
	// checks
	a_pulldown_write: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(wr_en && PADDR_IN == ADDR_PULLDOWN && PSTRB_IN[1:0] == 2'h3)
		##1 !wr_en
		|=> (PULLDOWN_ON_OUT == ($past(PWDATA_IN[PD_PINS-1:0], 2) & $past(PIN_IS_INPUT_IN) & ~$past(PULLUP_REQ_IN))))
		else $error("pull-down output does not follow the written value");

	a_pullup_wins: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		1'b1 |=> ((PULLDOWN_ON_OUT & $past(PULLUP_REQ_IN)) == '0))
		else $error("pull-down on while pull-up requested");

	a_data_loop: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		lb_q[LB_DATA_BIT] |=> (UART_RXD_OUT == $past(UART_TXD_IN) && !TX_PIN_OE_OUT))
		else $error("data loopback path wrong");

	a_rts_loop: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		lb_q[LB_RTS_BIT] |=> (UART_CTS_OUT == $past(UART_RTS_IN)))
		else $error("rts loopback path wrong");

	a_dtr_loop: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		lb_q[LB_DTR_BIT] |=> (UART_DSR_OUT == $past(UART_DTR_IN)))
		else $error("dtr loopback path wrong");

	a_rx_invert: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(!lb_q[LB_DATA_BIT] && ir_q[IR_INV_BIT]) |=> (UART_RXD_OUT != $past(sync2_q[SY_RX])))
		else $error("receive data not inverted");

	a_ir_setting: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(wr_en && PADDR_IN == ADDR_INFRARED && PSTRB_IN[0])
		|=> (INFRARED_CONTROL_EN_OUT == $past(PWDATA_IN[IR_EN_BIT])
		&& IR_PULSE_SIXTEENTHS_OUT == ($past(PWDATA_IN[IR_PULSE_BIT]) ? IR_PULSE_WIDE : IR_PULSE_NARROW)))
		else $error("infrared settings not applied");

	a_rx_wake: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(wk_q[WK_RX_BIT] && PIN_IS_INPUT_IN[PD_RX_BIT] && rx_prev_q && !sync2_q[SY_RX])
		|=> WAKE_EVENT_OUT)
		else $error("receive pin fall gave no wakeup");

	a_ring_wake: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(wk_q[WK_RING_BIT] && RING_PIN_IS_INPUT_IN && $fell(sync2_q[SY_RING]))
		|=> WAKE_EVENT_OUT)
		else $error("ring pin fall gave no wakeup");

	a_flush_auto: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		((fl_q[FL_OPEN_BIT] && $rose(TX_ENABLE_IN)) || (fl_q[FL_CLOSE_BIT] && $fell(TX_ENABLE_IN)))
		|=> TX_FLUSH_OUT)
		else $error("transmitter change gave no flush");

	a_flush_self: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(wr_en && PADDR_IN == ADDR_FLUSH && PSTRB_IN[0] && PWDATA_IN[FL_RESET_BIT]
		&& !TX_ENABLE_IN && !$past(TX_ENABLE_IN))
		##1 (!wr_en && !TX_ENABLE_IN) |-> TX_FLUSH_OUT ##1 !TX_FLUSH_OUT)
		else $error("flush reset did not pulse once");

	a_level_read: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
		(setup_rd && PADDR_IN == ADDR_LEVEL) |=> (PRDATA_OUT == DATA_W'($past(TX_LEVEL_IN, 2))))
		else $error("queue level read wrong");

endmodule

// >>> sim/ucc_cfg_top_test.sv
// Purpose: self-checking bench for the channel configuration registers
// Assumes: APB slave answers in the access cycle
// Notes:   flush and wake pulses are counted at every rising clock edge
`timescale 1ns/10ps
module ucc_cfg_top_test;
	import ucc_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd;
	logic        rdy, err, rxd, cts, dsr, txp, oe, irm, clko, wake, fl, wide, e, rtp, dtp;
	logic [2:0]  pul;
	logic [10:0] isin = 11'h7FF, pu = 11'h000, pdo;
	logic        txd = 1, rts = 1, dtr = 1, rxp = 1, ring = 1, ten = 0, rin = 1;
	logic [9:0]  lvl = 10'h000;
	logic [15:0] rv;
	int          n_mismatch = 0, checks_done = 0, cyc = 0, nfl = 0, nwk = 0, t;
	ucc_cfg_top u_dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(padr), .PWDATA_IN(pwd), .PSTRB_IN(4'hF), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
		.PIN_IS_INPUT_IN(isin), .PULLUP_REQ_IN(pu), .PULLDOWN_ON_OUT(pdo), .UART_TXD_IN(txd), .UART_RTS_IN(rts),
		.UART_DTR_IN(dtr), .UART_RXD_OUT(rxd), .UART_CTS_OUT(cts), .UART_DSR_OUT(dsr), .TX_PIN_OUT(txp),
		.TX_PIN_OE_OUT(oe), .RX_PIN_IN(rxp), .CTS_PIN_IN(1'b1), .DSR_PIN_IN(1'b1), .RTS_PIN_OUT(rtp), .DTR_PIN_OUT(dtp),
		.RING_OR_WAKE_PIN_IN(ring), .RING_PIN_IS_INPUT_IN(rin), .INFRARED_CONTROL_EN_OUT(irm),
		.IR_PULSE_SIXTEENTHS_OUT(pul), .CLOCK_OUT(clko), .WAKE_EVENT_OUT(wake), .TX_ENABLE_IN(ten),
		.TX_LEVEL_IN(lvl), .TX_FLUSH_OUT(fl), .TX_WIDE_OUT(wide));
	always #4 clk = ~clk;
	// ==========================================================
	// bus tasks and checks
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// request held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1; pwr <= w; padr <= a; pwd <= {16'h0000, d}; pen <= 0;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		rv = prd[15:0]; e = err; psel <= 0; pen <= 0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %0h expected %0h", $time, g, x);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] x);
		xfer(0, a, 16'h0000);
		chk(rv, x);
	endtask
	// bounded wait while the generated clock holds level v
	task automatic wt(input logic v);
		t = 0;
		while (clko === v && t < 50)
		begin
			@(posedge clk);
			t++;
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (fl === 1'b1) nfl++;
		if (wake === 1'b1) nwk++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			test_done;
		end
	end
	// ==========================================================
	// tests
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		rdc(ADDR_PULLDOWN, 16'h0000);
		rdc(ADDR_WAKEUP, 16'h0004);
		rdc(ADDR_FLUSH, 16'h0000);
		chk(pul, 3'h3);
		ring <= 0;
		repeat (6) @(posedge clk);
		chk(nwk, 1);
		ring <= 1;
		xfer(1, ADDR_WAKEUP, 16'h0008);
		ring <= 0; rxp <= 0;
		repeat (6) @(posedge clk);
		chk(nwk, 2);
		ring <= 1; rxp <= 1;
		xfer(1, ADDR_WAKEUP, 16'h0004);
		rin <= 0; ring <= 0;
		repeat (6) @(posedge clk);
		chk(nwk, 2);
		ring <= 1; pu <= 11'h401; isin <= 11'h7DF;
		xfer(1, ADDR_PULLDOWN, 16'h07FF);
		rdc(ADDR_PULLDOWN, 16'h07FF);
		chk(pdo, 11'h3DE);
		$display("test reset, wake, pull-down done");
		txd <= 0; rts <= 0; dtr <= 0;
		xfer(1, ADDR_LOOPBACK, 16'h0007);
		repeat (3) @(posedge clk);
		chk({rxd, cts, dsr, oe, rtp, dtp}, 6'h00);
		xfer(1, ADDR_LOOPBACK, 16'h0000);
		xfer(1, ADDR_INFRARED, 16'h0007);
		repeat (4) @(posedge clk);
		chk({oe, txp, cts, dsr, irm, pul, rxd}, 9'h178);
		$display("test loopback and infrared done");
		xfer(1, ADDR_CLOCKOUT, 16'h0102);
		wt(0); wt(1);
		chk(t, 6);
		wt(0);
		chk(t, 12);
		xfer(1, ADDR_CLOCKOUT, 16'h0000);
		repeat (20) @(posedge clk);
		chk(clko, 0);
		xfer(1, ADDR_FLUSH, 16'h0003);
		repeat (3) @(posedge clk);
		chk(nfl, 1);
		ten <= 1;
		repeat (3) @(posedge clk);
		ten <= 0;
		repeat (3) @(posedge clk);
		chk(nfl, 2);
		xfer(1, ADDR_FLUSH, 16'h0004);
		ten <= 1;
		repeat (3) @(posedge clk);
		ten <= 0;
		repeat (3) @(posedge clk);
		chk(nfl, 3);
		lvl <= 10'h2A5;
		xfer(1, ADDR_LEVEL, 16'h0000);
		rdc(ADDR_LEVEL, 16'h02A5);
		xfer(1, ADDR_WIDE, 16'h0001);
		rdc(ADDR_WIDE, 16'h0001);
		chk(wide, 1);
		xfer(0, 12'h200, 16'h0000);
		chk({e, rv}, 17'h10000);
		$display("test clock, flush, level, wide done");
		test_done;
	end
endmodule
